// file: drive_setpoint_select.sv
// Setpoint source, start source, fault snapshot and display stepping
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
// Operation
// [R1] Fault latches five values until next fault
// [R2] Stored setpoint 0.00 to max, 0.01 steps
// [R3] Selector 0 uses stored setpoint
// [R4] Running: bus write or keys change setpoint
// [R5] Keys while stopped are not retained
// [R6] Bus write while stopped is retained
// [R7] Selector 1 uses analog input, volt or 4-20
// [R8] Selector 2 reserved, current input terminal
// [R9] Selector 3 uses external panel knob
// [R10] Selector 4 follows up/down terminals
// [R11] Selector 5 uses serial setpoint
// [R12] Function 15 makes up, 16 down
// [R13] Setpoint source range 0-5, default 0
// [R14] Start source 0 keypad, 1 terminals, 2 serial
// [R15] Start source resets to keypad
// [R16] Power-on standby shows setpoint, indicator lit
// [R17] Run key starts, run and forward lit
// [R18] Display key cycles four views
// [R19] Stored source with option 0 keeps value
// [R20] Memory option 0 keeps, 1 discards
// [R21] Up/down steps per tick, clamped min/max
// [R22] Analog scaled linearly to max frequency
module drive_setpoint_select #(
	parameter int UPDOWN_TICK = setpoint_pkg::UPDOWN_TICK_CYC
) (
	// Clock and reset
	input  wire logic                              clk_i,
	input  wire logic                              rst_i,
	// AHB-Lite slave
	input  wire logic                              hsel_i,
	input  wire logic [31:0]                       haddr_i,
	input  wire logic [1:0]                        htrans_i,
	input  wire logic                              hwrite_i,
	input  wire logic [2:0]                        hsize_i,
	input  wire logic [31:0]                       hwdata_i,
	input  wire logic                              hready_i,
	output logic      [31:0]                       hrdata_o,
	output logic                                   hreadyout_o,
	output logic                                   hresp_o,
	// Keypad and terminals
	input  wire setpoint_pkg::keys_t               keys_i,
	input  wire logic                              multifunction_input_one_i,
	input  wire logic                              multifunction_input_two_i,
	input  wire logic                              term_run_i,
	// Setpoint sources and serial run
	input  wire logic [setpoint_pkg::ADC_W-1:0]    analog_setpoint_input_i,
	input  wire logic                              analog_is_current_i,
	input  wire logic [setpoint_pkg::ADC_W-1:0]    current_setpoint_input_i,
	input  wire logic [setpoint_pkg::ADC_W-1:0]    panel_knob_i,
	input  wire logic [setpoint_pkg::FREQ_W-1:0]   serial_setpoint_i,
	input  wire logic                              serial_run_i,
	// Drive state
	input  wire setpoint_pkg::measure_t            measure_i,
	input  wire logic                              fault_i,
	// Outputs
	output logic      [setpoint_pkg::FREQ_W-1:0]   freq_cmd_o,
	output logic                                   run_o,
	output logic                                   run_indicator_o,
	output logic                                   forward_indicator_o,
	output logic                                   setpoint_indicator_o,
	output setpoint_pkg::view_t                    view_o
);
	localparam int FW = setpoint_pkg::FREQ_W;

	// ****************************************
	// Registers
	// ****************************************
	logic [FW-1:0] stored_setpoint;
	logic [FW-1:0] working_setpoint;
	logic [FW-1:0] updown_setpoint;
	logic [2:0]    setpoint_source_sel;
	logic [1:0]    start_source_sel;
	logic          updown_memory_option;
	logic [4:0]    input_one_function;
	logic [4:0]    input_two_function;
	logic [FW-1:0] max_freq;
	logic [FW-1:0] min_freq;
	logic [FW-1:0] fault_setpoint_snapshot;
	setpoint_pkg::measure_t fault_snap;
	logic          running;
	logic          fault_d;
	logic          key_d;
	logic          run_key_d;
	logic [31:0]   tick_cnt;
	logic          tick;
	logic [FW-1:0] next_freq;

	// AHB data-phase capture
	logic          wr_pend;
	logic [7:0]    wr_addr;

	function automatic logic [FW-1:0] clamp(input logic [FW-1:0] v, input logic [FW-1:0] lo,
		input logic [FW-1:0] hi);
		if (v > hi)
		begin
			return hi;
		end
		else if (v < lo)
		begin
			return lo;
		end
		return v;
	endfunction

	// Linear scale of a code span onto zero..max frequency
	function automatic logic [FW-1:0] scale(input logic [11:0] code, input logic [11:0] base,
		input logic [FW-1:0] fmax);
		logic [11:0] span;
		logic [11:0] off;
		logic [FW+11:0] prod;
		span = setpoint_pkg::ADC_FULL - base;
		off = (code > base) ? code - base : 12'h000;
		prod = off * fmax;
		return FW'(prod / (FW+12)'(span)); // [R22]
	endfunction

	// Terminal roles come from their function codes
	function automatic logic term_has(input logic [4:0] code, input logic [4:0] fn);
		return code == fn; // [R12]
	endfunction

	logic up_act;
	logic down_act;
	assign up_act = (term_has(input_one_function, setpoint_pkg::FUNC_UP)
		&& multifunction_input_one_i)
		|| (term_has(input_two_function, setpoint_pkg::FUNC_UP) && multifunction_input_two_i);
	assign down_act = (term_has(input_one_function, setpoint_pkg::FUNC_DOWN)
		&& multifunction_input_one_i)
		|| (term_has(input_two_function, setpoint_pkg::FUNC_DOWN) && multifunction_input_two_i);

	// ****************************************
	// Bus slave, zero wait states
	// ****************************************
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end
		else if (hready_i)
		begin
			wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
			wr_addr <= haddr_i[7:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hrdata_o <= 32'h00000000;
		end
		else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
		begin
			if (haddr_i[7:0] == setpoint_pkg::OFF_STORED_SETPOINT)
				hrdata_o <= 32'(stored_setpoint);
			else if (haddr_i[7:0] == setpoint_pkg::OFF_SOURCE_SEL)
				hrdata_o <= 32'(setpoint_source_sel);
			else if (haddr_i[7:0] == setpoint_pkg::OFF_START_SEL)
				hrdata_o <= 32'(start_source_sel);
			else if (haddr_i[7:0] == setpoint_pkg::OFF_UPDOWN_MEM)
				hrdata_o <= 32'(updown_memory_option);
			else if (haddr_i[7:0] == setpoint_pkg::OFF_INPUT_FUNC)
				hrdata_o <= {19'h00000, input_two_function, 3'h0, input_one_function};
			else if (haddr_i[7:0] == setpoint_pkg::OFF_FREQ_LIMITS)
				hrdata_o <= 32'({min_freq[15:0], max_freq[15:0]});
			else if (haddr_i[7:0] == setpoint_pkg::OFF_STATUS)
				hrdata_o <= {28'h0000000, view_o, fault_i, running};
			else if (haddr_i[7:0] == setpoint_pkg::OFF_ACTIVE_SETPOINT)
				hrdata_o <= 32'(next_freq);
			else if (haddr_i[7:0] == setpoint_pkg::OFF_FLT_SETPOINT)
				hrdata_o <= 32'(fault_setpoint_snapshot);
			else if (haddr_i[7:0] == setpoint_pkg::OFF_FLT_OUTFREQ)
				hrdata_o <= 32'(fault_snap.outfreq);
			else if (haddr_i[7:0] == setpoint_pkg::OFF_FLT_CURRENT)
				hrdata_o <= 32'(fault_snap.current);
			else if (haddr_i[7:0] == setpoint_pkg::OFF_FLT_VOLTAGE)
				hrdata_o <= 32'(fault_snap.voltage);
			else if (haddr_i[7:0] == setpoint_pkg::OFF_FLT_BUSVOLT)
				hrdata_o <= 32'(fault_snap.busvolt);
			else
				hrdata_o <= 32'h00000000;
		end
	end

	logic wr_stored;
	assign wr_stored = wr_pend && wr_addr == setpoint_pkg::OFF_STORED_SETPOINT;

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			setpoint_source_sel  <= setpoint_pkg::SRC_STORED; // [R13]
			start_source_sel     <= setpoint_pkg::START_KEYPAD; // [R15]
			updown_memory_option <= 1'b0; // [R20]
			input_one_function   <= 5'h00;
			input_two_function   <= 5'h00;
			max_freq             <= setpoint_pkg::MAX_FREQ_RST;
			min_freq             <= setpoint_pkg::MIN_FREQ_RST;
		end
		else if (wr_pend)
		begin
			// Out-of-range codes are dropped so the selectors stay legal
			if (wr_addr == setpoint_pkg::OFF_SOURCE_SEL && hwdata_i[2:0] <= setpoint_pkg::SRC_SERIAL
				&& hwdata_i[31:3] == 29'h00000000)
				setpoint_source_sel <= hwdata_i[2:0]; // [R13]
			else if (wr_addr == setpoint_pkg::OFF_START_SEL && hwdata_i[1:0] <= setpoint_pkg::START_SERIAL
				&& hwdata_i[31:2] == 30'h00000000)
				start_source_sel <= hwdata_i[1:0]; // [R14]
			else if (wr_addr == setpoint_pkg::OFF_UPDOWN_MEM)
				updown_memory_option <= hwdata_i[0]; // [R20]
			else if (wr_addr == setpoint_pkg::OFF_INPUT_FUNC)
			begin
				input_one_function <= hwdata_i[4:0]; // [R12]
				input_two_function <= hwdata_i[12:8];
			end
			else if (wr_addr == setpoint_pkg::OFF_FREQ_LIMITS)
			begin
				max_freq <= clamp({1'b0, hwdata_i[15:0]}, 17'h00000, setpoint_pkg::FREQ_CEILING);
				min_freq <= {1'b0, hwdata_i[31:16]};
			end
		end
	end

	// ****************************************
	// Digital setpoint
	// ****************************************
	// Stored value only moves on bus writes; keys act on a working copy
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			stored_setpoint <= 17'h00000;
		else if (wr_stored)
			stored_setpoint <= clamp(hwdata_i[FW-1:0], 17'h00000, max_freq); // [R2] [R6] [R19]
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			working_setpoint <= 17'h00000;
		else if (wr_stored)
			working_setpoint <= clamp(hwdata_i[FW-1:0], 17'h00000, max_freq); // [R4]
		else if (!running)
			working_setpoint <= stored_setpoint; // [R5]
		else if (keys_i.up && !key_d && working_setpoint < max_freq)
			working_setpoint <= working_setpoint + setpoint_pkg::FREQ_STEP; // [R4]
		else if (keys_i.down && !key_d && working_setpoint != 17'h00000)
			working_setpoint <= working_setpoint - setpoint_pkg::FREQ_STEP; // [R4]
	end

	// ****************************************
	// Up/down terminals
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tick_cnt <= 32'h00000000;
			tick <= 1'b0;
		end
		else
		begin
			tick <= tick_cnt == 32'(UPDOWN_TICK - 1);
			tick_cnt <= (tick_cnt == 32'(UPDOWN_TICK - 1)) ? 32'h00000000 : tick_cnt + 32'h00000001;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			updown_setpoint <= 17'h00000;
		else if (!running && updown_memory_option)
			updown_setpoint <= 17'h00000; // [R20]
		else if (tick && up_act && !down_act && updown_setpoint < max_freq)
			updown_setpoint <= clamp(updown_setpoint + setpoint_pkg::FREQ_STEP, min_freq,
				max_freq); // [R10] [R21]
		else if (tick && down_act && !up_act && updown_setpoint > min_freq)
			updown_setpoint <= clamp(updown_setpoint - setpoint_pkg::FREQ_STEP, min_freq,
				max_freq); // [R10] [R21]
	end

	// ****************************************
	// Source selection
	// ****************************************
	always_comb
	begin
		case (setpoint_source_sel)
			setpoint_pkg::SRC_STORED:
				next_freq = working_setpoint; // [R3]
			setpoint_pkg::SRC_ANALOG:
				next_freq = scale(analog_setpoint_input_i,
					analog_is_current_i ? setpoint_pkg::ADC_4MA : 12'h000, max_freq); // [R7]
			setpoint_pkg::SRC_RESERVED:
				next_freq = scale(current_setpoint_input_i, 12'h000, max_freq); // [R8]
			setpoint_pkg::SRC_PANEL:
				next_freq = scale(panel_knob_i, 12'h000, max_freq); // [R9]
			setpoint_pkg::SRC_UPDOWN:
				next_freq = updown_setpoint; // [R10]
			default:
				next_freq = clamp(serial_setpoint_i, 17'h00000, max_freq); // [R11]
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			freq_cmd_o <= 17'h00000;
		else
			freq_cmd_o <= running ? clamp(next_freq, min_freq, max_freq) : 17'h00000;
	end

	// ****************************************
	// Run control
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			running <= 1'b0; // [R16]
			run_key_d <= 1'b0;
			key_d <= 1'b0;
		end
		else
		begin
			run_key_d <= keys_i.run;
			key_d <= keys_i.up || keys_i.down;
			if (fault_i)
				running <= 1'b0;
			else if (start_source_sel == setpoint_pkg::START_KEYPAD)
			begin
				if (keys_i.stop)
					running <= 1'b0;
				else if (keys_i.run && !run_key_d)
					running <= 1'b1; // [R14] [R17]
			end
			else if (start_source_sel == setpoint_pkg::START_TERM)
				running <= term_run_i; // [R14]
			else
				running <= serial_run_i; // [R14]
		end
	end

	assign run_o = running;
	assign run_indicator_o = running; // [R17]
	assign forward_indicator_o = running; // [R17]
	assign setpoint_indicator_o = view_o == setpoint_pkg::VIEW_SETPOINT; // [R16]

	// ****************************************
	// Display and fault snapshot
	// ****************************************
	logic disp_d;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			view_o <= setpoint_pkg::VIEW_SETPOINT; // [R16]
			disp_d <= 1'b0;
		end
		else
		begin
			disp_d <= keys_i.display;
			if (keys_i.display && !disp_d)
				view_o <= setpoint_pkg::view_t'(view_o + 2'h1); // [R18]
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fault_d <= 1'b0;
			fault_setpoint_snapshot <= 17'h00000;
			fault_snap <= '0;
		end
		else
		begin
			fault_d <= fault_i;
			if (fault_i && !fault_d)
			begin
				fault_setpoint_snapshot <= next_freq; // [R1]
				fault_snap <= measure_i; // [R1]
			end
		end
	end
endmodule

// file: setpoint_pkg.sv
// Package with register map, field widths and constants for setpoint selection
package setpoint_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFF_STORED_SETPOINT = 8'h00;
	localparam logic [7:0] OFF_SOURCE_SEL      = 8'h04;
	localparam logic [7:0] OFF_START_SEL       = 8'h08;
	localparam logic [7:0] OFF_UPDOWN_MEM      = 8'h0C;
	localparam logic [7:0] OFF_INPUT_FUNC      = 8'h10;
	localparam logic [7:0] OFF_FREQ_LIMITS     = 8'h14;
	localparam logic [7:0] OFF_STATUS          = 8'h18;
	localparam logic [7:0] OFF_ACTIVE_SETPOINT = 8'h1C;
	localparam logic [7:0] OFF_FLT_SETPOINT    = 8'h20;
	localparam logic [7:0] OFF_FLT_OUTFREQ     = 8'h24;
	localparam logic [7:0] OFF_FLT_CURRENT     = 8'h28;
	localparam logic [7:0] OFF_FLT_VOLTAGE     = 8'h2C;
	localparam logic [7:0] OFF_FLT_BUSVOLT     = 8'h30;

	// ****************************************
	// Widths and values
	// ****************************************
	localparam int FREQ_W = 17;
	localparam int MEAS_W = 16;
	localparam int ADC_W  = 12;
	localparam logic [FREQ_W-1:0] FREQ_CEILING  = 17'h1869C; // 999.96 Hz in 0.01 units
	localparam logic [FREQ_W-1:0] FREQ_STEP     = 17'h00001; // 0.01 Hz
	localparam logic [FREQ_W-1:0] MAX_FREQ_RST  = 17'h01388; // 50.00 Hz
	localparam logic [FREQ_W-1:0] MIN_FREQ_RST  = 17'h00000;
	localparam logic [2:0] SRC_STORED   = 3'h0;
	localparam logic [2:0] SRC_ANALOG   = 3'h1;
	localparam logic [2:0] SRC_RESERVED = 3'h2;
	localparam logic [2:0] SRC_PANEL    = 3'h3;
	localparam logic [2:0] SRC_UPDOWN   = 3'h4;
	localparam logic [2:0] SRC_SERIAL   = 3'h5;
	localparam logic [1:0] START_KEYPAD = 2'h0;
	localparam logic [1:0] START_TERM   = 2'h1;
	localparam logic [1:0] START_SERIAL = 2'h2;
	localparam logic [4:0] FUNC_UP      = 5'h0F;
	localparam logic [4:0] FUNC_DOWN    = 5'h10;
	localparam logic [ADC_W-1:0] ADC_FULL   = 12'hFFF;
	localparam logic [ADC_W-1:0] ADC_4MA    = 12'h333; // 4 mA on a 0..20 mA scale
	localparam int CLK_MHZ      = 250;
	localparam int UPDOWN_TICK_MS = 10;
	localparam int UPDOWN_TICK_CYC = UPDOWN_TICK_MS * 1000 * CLK_MHZ;

	typedef enum logic [1:0] {VIEW_SETPOINT, VIEW_OUTFREQ, VIEW_CURRENT, VIEW_STATUS} view_t;

	typedef struct packed {
		logic [FREQ_W-1:0] outfreq;
		logic [MEAS_W-1:0] current;
		logic [MEAS_W-1:0] voltage;
		logic [MEAS_W-1:0] busvolt;
	} measure_t;

	typedef struct packed {
		logic run;
		logic stop;
		logic up;
		logic down;
		logic display;
	} keys_t;
endpackage

// file: drive_setpoint_select_props.sv
// Port checker for the setpoint selector
`timescale 1ns/1ps
module drive_setpoint_select_props (
	// Clock and reset
	input wire logic                            clk_i,
	input wire logic                            rst_i,
	// Watched signals
	input wire setpoint_pkg::keys_t             keys_i,
	input wire logic                            term_run_i,
	input wire logic                            serial_run_i,
	input wire logic                            fault_i,
	input wire logic [setpoint_pkg::FREQ_W-1:0] freq_cmd_o,
	input wire logic                            run_o,
	input wire logic                            run_indicator_o,
	input wire logic                            forward_indicator_o,
	input wire logic                            setpoint_indicator_o,
	input wire setpoint_pkg::view_t             view_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****************************************
	// Assertions
	// ****************************************
	chk_stop_zero: assert property (!run_o && $past(!run_o) |-> freq_cmd_o == '0)
		else $error("frequency command not zero while stopped");
	chk_run_lamps: assert property (run_indicator_o == run_o && forward_indicator_o == run_o)
		else $error("run lamps disagree with run state");
	chk_view_flag: assert property (setpoint_indicator_o == (view_o == setpoint_pkg::VIEW_SETPOINT))
		else $error("setpoint lamp disagrees with view");
	chk_view_quiet: assert property (!keys_i.display [*3] |=> $stable(view_o))
		else $error("view moved without display key");
	chk_view_order: assert property ($changed(view_o) |-> 2'(view_o) == 2'($past(view_o) + 2'h1))
		else $error("view skipped a step");
	chk_run_cause: assert property ($rose(run_o) |-> $past(keys_i.run) || $past(keys_i.run, 2)
		|| $past(keys_i.run, 3) || $past(term_run_i) || $past(serial_run_i))
		else $error("run started without a start request");
	chk_stop_key: assert property (keys_i.stop [*3] |-> !run_o)
		else $error("stop key did not stop the drive");
	chk_fault_halt: assert property (fault_i [*3] |-> !run_o)
		else $error("drive kept running in a fault");
	cov_run: cover property ($rose(run_o));
	cov_view: cover property ($changed(view_o));
	cov_fault: cover property ($rose(fault_i));
endmodule

// file: operator_side.sv
// Model of keypad, terminals, panel knob and serial host
`timescale 1ns/1ps
module operator_side (
	// Clock
	input  wire logic                            clk_i,
	// Operator signals
	output setpoint_pkg::keys_t                  keys_o,
	output logic                                 term_up_o,
	output logic                                 term_down_o,
	output logic [setpoint_pkg::ADC_W-1:0]       knob_o,
	output logic [setpoint_pkg::FREQ_W-1:0]      serial_setpoint_o
);
	initial
	begin
		keys_o = '0;
		term_up_o = 1'b0;
		term_down_o = 1'b0;
		knob_o = '0;
		serial_setpoint_o = '0;
	end
	// Held three cycles so a level-sensed stop is seen as well as an edge
	task automatic press(input int k);
		@(posedge clk_i);
		keys_o[k] <= 1'b1;
		repeat (3) @(posedge clk_i);
		keys_o[k] <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic terms(input logic up, input logic dn);
		@(posedge clk_i);
		term_up_o <= up;
		term_down_o <= dn;
	endtask
	task automatic remote(input logic [11:0] k, input logic [16:0] s);
		@(posedge clk_i);
		knob_o <= k;
		serial_setpoint_o <= s;
	endtask
endmodule

// file: drive_setpoint_select_tb.sv
// Self-checking bench for the setpoint selector
`timescale 1ns/1ps
module drive_setpoint_select_tb;
	localparam int TICK = 8;
	logic clk_i, rst_i, hsel, hwrite, hreadyout, hresp, fault, run, run_ind, forward_indicator, sp_ind, up, dn;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [11:0] analog, cur, knob;
	logic [16:0] freq, ser, f0;
	logic        trun, srun, acur;
	setpoint_pkg::keys_t    keys;
	setpoint_pkg::measure_t meas;
	setpoint_pkg::view_t    view;
	int seed = 32'h197E;
	int miscompares = 0;
	int checks_done = 0;
	drive_setpoint_select #(.UPDOWN_TICK(TICK)) drive_setpoint_select_i (.clk_i(clk_i),
		.rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
		.hreadyout_o(hreadyout), .hresp_o(hresp), .keys_i(keys), .multifunction_input_one_i(up),
		.multifunction_input_two_i(dn), .term_run_i(trun), .analog_setpoint_input_i(analog),
		.analog_is_current_i(acur), .current_setpoint_input_i(cur), .panel_knob_i(knob),
		.serial_setpoint_i(ser), .serial_run_i(srun), .measure_i(meas), .fault_i(fault),
		.freq_cmd_o(freq), .run_o(run), .run_indicator_o(run_ind), .forward_indicator_o(forward_indicator),
		.setpoint_indicator_o(sp_ind), .view_o(view));
	operator_side operator_side_i (.clk_i(clk_i), .keys_o(keys), .term_up_o(up),
		.term_down_o(dn), .knob_o(knob), .serial_setpoint_o(ser));
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// ****************************************
	// Checks and bus tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk_i); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_i); while (hreadyout !== 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(hrdata, exp);
		chk(32'(hresp), 32'h0);
	endtask
	// Linear scale of an input code above its base onto zero..max frequency
	function automatic logic [16:0] exp_scale(input int c, input int b);
		return (c > b) ? 17'((c - b) * int'(setpoint_pkg::MAX_FREQ_RST)
			/ (int'(setpoint_pkg::ADC_FULL) - b)) : 17'h00000;
	endfunction
	task automatic fchk(input logic [16:0] e);
		for (int i = 0; i < 40 && freq !== e; i++)
			@(posedge clk_i);
		chk(32'(freq), 32'(e));
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#(100000 * 4);
		miscompares++;
		summarize();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		logic [31:0] s;
		setpoint_pkg::measure_t snap;
		{hsel, hwrite, htrans, haddr, hwdata, analog, cur, meas, fault, trun, srun, acur} = '0;
		rst_i = 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(32'(freq), 32'h0);
		chk(32'(sp_ind), 32'h1);
		rd(setpoint_pkg::OFF_SOURCE_SEL, 32'h0);
		rd(setpoint_pkg::OFF_START_SEL, 32'h0);
		rd(setpoint_pkg::OFF_UPDOWN_MEM, 32'h0);
		rd(8'h3C, 32'h0);
		$display("reset test done");
		for (int i = 0; i < 4; i++)
		begin
			s = 32'($unsigned($random(seed)) % 32'h1388);
			bus(1'b1, setpoint_pkg::OFF_STORED_SETPOINT, s);
			rd(setpoint_pkg::OFF_STORED_SETPOINT, s);
		end
		bus(1'b1, setpoint_pkg::OFF_SOURCE_SEL, 32'h6);
		rd(setpoint_pkg::OFF_SOURCE_SEL, 32'h0);
		for (int k = 3; k >= 0; k--)
		begin
			bus(1'b1, setpoint_pkg::OFF_START_SEL, 32'(k));
			rd(setpoint_pkg::OFF_START_SEL, 32'(k % 3));
		end
		$display("register test done");
		bus(1'b1, setpoint_pkg::OFF_STORED_SETPOINT, 32'h00000BB8);
		operator_side_i.press(4);
		chk(32'({run, forward_indicator, run_ind}), 32'h7);
		fchk(17'h00BB8);
		operator_side_i.press(2);
		fchk(17'h00BB9);
		operator_side_i.press(3);
		fchk(17'h00000);
		operator_side_i.press(2);
		operator_side_i.press(4);
		fchk(17'h00BB8);
		bus(1'b1, setpoint_pkg::OFF_START_SEL, 32'h1);
		fchk(17'h00000);
		trun <= 1'b1;
		fchk(17'h00BB8);
		bus(1'b1, setpoint_pkg::OFF_START_SEL, 32'h2);
		fchk(17'h00000);
		srun <= 1'b1;
		fchk(17'h00BB8);
		bus(1'b1, setpoint_pkg::OFF_START_SEL, 32'h0);
		srun <= 1'b0;
		trun <= 1'b0;
		$display("run test done");
		s = 32'($unsigned($random(seed)) % 32'h1388);
		operator_side_i.remote(12'hFFF, 17'(s));
		analog <= 12'hFFF;
		bus(1'b1, setpoint_pkg::OFF_SOURCE_SEL, 32'h5);
		fchk(17'(s));
		bus(1'b1, setpoint_pkg::OFF_SOURCE_SEL, 32'h1);
		fchk(setpoint_pkg::MAX_FREQ_RST);
		s = 32'($unsigned($random(seed)) % 32'h1000);
		acur <= 1'b1;
		analog <= s[11:0];
		fchk(exp_scale(s, setpoint_pkg::ADC_4MA));
		bus(1'b1, setpoint_pkg::OFF_SOURCE_SEL, 32'h3);
		fchk(setpoint_pkg::MAX_FREQ_RST);
		s = 32'($unsigned($random(seed)) % 32'h1000);
		cur <= s[11:0];
		bus(1'b1, setpoint_pkg::OFF_SOURCE_SEL, 32'h2);
		rd(setpoint_pkg::OFF_SOURCE_SEL, 32'h2);
		fchk(exp_scale(s, 0));
		$display("source test done");
		bus(1'b1, setpoint_pkg::OFF_INPUT_FUNC, 32'h0000100F);
		rd(setpoint_pkg::OFF_INPUT_FUNC, 32'h0000100F);
		bus(1'b1, setpoint_pkg::OFF_SOURCE_SEL, 32'h4);
		fchk(setpoint_pkg::MIN_FREQ_RST);
		f0 = freq;
		operator_side_i.terms(1'b1, 1'b0);
		repeat (10 * TICK) @(posedge clk_i);
		chk(32'(freq > f0 && freq <= f0 + 17'd11), 32'h1);
		operator_side_i.terms(1'b1, 1'b1);
		repeat (2) @(posedge clk_i);
		f0 = freq;
		repeat (6 * TICK) @(posedge clk_i);
		chk(32'(freq), 32'(f0));
		operator_side_i.terms(1'b0, 1'b1);
		repeat (20 * TICK) @(posedge clk_i);
		fchk(setpoint_pkg::MIN_FREQ_RST);
		operator_side_i.terms(1'b1, 1'b0);
		repeat (4 * TICK) @(posedge clk_i);
		operator_side_i.terms(1'b0, 1'b0);
		bus(1'b1, setpoint_pkg::OFF_UPDOWN_MEM, 32'h1);
		operator_side_i.press(3);
		operator_side_i.press(4);
		fchk(setpoint_pkg::MIN_FREQ_RST);
		$display("up/down test done");
		for (int k = 1; k <= 4; k++)
		begin
			operator_side_i.press(0);
			chk(32'(view), 32'(k % 4));
			chk(32'(sp_ind), 32'(k == 4));
		end
		$display("display test done");
		bus(1'b1, setpoint_pkg::OFF_SOURCE_SEL, 32'h0);
		fchk(17'h00BB8);
		for (int n = 0; n < 2; n++)
		begin
			@(posedge clk_i);
			meas <= 65'({$random(seed), $random(seed), $random(seed)});
			@(posedge clk_i);
			fault <= 1'b1;
			repeat (4) @(posedge clk_i);
			snap = meas;
			fault <= 1'b0;
			meas <= ~meas;
			rd(setpoint_pkg::OFF_FLT_SETPOINT, 32'h00000BB8);
			rd(setpoint_pkg::OFF_FLT_OUTFREQ, 32'(snap.outfreq));
			rd(setpoint_pkg::OFF_FLT_CURRENT, 32'(snap.current));
			rd(setpoint_pkg::OFF_FLT_VOLTAGE, 32'(snap.voltage));
			rd(setpoint_pkg::OFF_FLT_BUSVOLT, 32'(snap.busvolt));
		end
		$display("fault test done");
		summarize();
	end
endmodule
bind drive_setpoint_select drive_setpoint_select_props drive_setpoint_select_props_i (
	.clk_i(clk_i), .rst_i(rst_i), .keys_i(keys_i), .term_run_i(term_run_i),
	.serial_run_i(serial_run_i), .fault_i(fault_i), .freq_cmd_o(freq_cmd_o), .run_o(run_o),
	.run_indicator_o(run_indicator_o), .forward_indicator_o(forward_indicator_o),
	.setpoint_indicator_o(setpoint_indicator_o), .view_o(view_o));
